// [verif/logic_trigger_unit_bench.sv]
/*
  bench for ltu_core: register tasks and trigger trials per class.
  assumes ltu_checker and ltu_chan_model are compiled before it.
*/
`timescale 1ns/100ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
  num_errors++; $display("unexpected %s: expected %h seen %h", n, e, s); \
  end end
module logic_trigger_unit_bench;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic core_clk, nrst, regWr, regRd, trigPulse, acqStart;
  logic [7:0] regAddr;
  logic [31:0] regWrData, regRdData, chLevel, ana;
  logic [3:0] chIn, lv;
  logic linkOn, linkClk, dOn, dBit;
  int dDly, num_errors, cmp_count;
  logic [7:0] ra [6] = '{ltu_pkg::REG_SRCSEL, ltu_pkg::REG_SETUP,
    ltu_pkg::REG_HOLD, ltu_pkg::REG_HOLDOFF, ltu_pkg::REG_THRESH, 8'h30};
  logic [31:0] rv [6] = '{32'h4, 32'h1, 32'h1, 32'h3F, 32'h80808080, 32'h0};
  ltu_core #(.HOLDOFF_MAX(32'h3E8)) u_dut (
    .core_clk(core_clk), .nrst(nrst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .chIn(chIn), .chLevel(chLevel),
    .trigPulse(trigPulse), .acqStart(acqStart));
  ltu_chan_model u_chan (.chLevel(chLevel), .anaLevel(ana), .chIn(chIn));
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      ana[8*i +: 8] = lv[i] ? 8'hF0 : 8'h10;
    end
    if (linkOn) ana[31:24] = linkClk ? 8'hF0 : 8'h10;
    if (dOn) ana[7:0] = dBit ? 8'hF0 : 8'h10;
  end
  // ------------------------------------------------------------------
  // clocks; the link clock stands still while off
  // ------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    linkClk = 1'b0;
    forever #80 linkClk = linkOn ? ~linkClk : 1'b0;
  end
  always @(posedge linkClk) begin
    if (dOn) dBit <= #(dDly) ~dBit;
  end
  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  function automatic logic [31:0] mk(logic [1:0] cl, fn, logic wh, eg);
    return {24'h0, 1'b0, eg, 1'b0, wh, fn, cl};
  endfunction : mk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1;
    d = regRdData;
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, string n);
    logic [31:0] d;
    rd(a, d);
    `CHK(n, e, d)
  endtask : rdc
  task automatic watch(input int n, output logic t, output logic a);
    t = 1'b0;
    a = 1'b0;
    for (int i = 0; i < n && !a; i++) begin
      @(posedge core_clk);
      #1;
      t = t | trigPulse;
      a = a | acqStart;
    end
  endtask : watch
  // inputs settle past the synchroniser before the run bit goes up
  task automatic trial(input logic [31:0] c, input logic e);
    logic [31:0] d;
    logic t, a;
    repeat (4) @(posedge core_clk);
    wr(ltu_pkg::REG_CTRL, c | 32'h100);
    watch(300, t, a);
    `CHK("trigger", {e, e}, {t, a})
    rd(ltu_pkg::REG_STATUS, d);
    `CHK("class", c[1:0], d[1:0])
    wr(ltu_pkg::REG_CTRL, 32'h0);
  endtask : trial
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    logic [31:0] c;
    logic f, al, an, t, a;
    {nrst, regWr, regRd, regAddr, regWrData} = '0;
    {lv, linkOn, dOn, dBit} = '0;
    {num_errors, cmp_count} = '0;
    dDly = 4;
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      rdc(ra[k], rv[k], "reset value");
    end
    wr(ltu_pkg::REG_SETUP, 32'hFFFB);
    rdc(ltu_pkg::REG_HOLD, 32'h6, "hold adjust");
    // the register keeps the raw value; only the count is clamped
    wr(ltu_pkg::REG_HOLDOFF, 32'h1388);
    rdc(ltu_pkg::REG_HOLDOFF, 32'h1388, "holdoff max");
    // below the minimum: the gap assertion sees the clamp where two trials in a row trigger
    wr(ltu_pkg::REG_HOLDOFF, 32'h5);
    rdc(ltu_pkg::REG_HOLDOFF, 32'h5, "holdoff min");
    // channel one high, channel two low: all, none or some met
    wr(ltu_pkg::REG_PRECOND, 32'h9);
    for (int k = 0; k < 24; k++) begin
      al = k < 8;
      an = k < 8 || k >= 16;
      lv <= k < 8 ? 4'h1 : (k < 16 ? 4'h2 : 4'h3);
      f = (k[1] ? an : al) ^ k[0] ^ k[2];
      c = mk(ltu_pkg::CLASS_PATTERN, k[1:0], k[2], 1'b0);
      trial(c, f);
    end
    // fourth channel precondition low must be ignored in state class
    wr(ltu_pkg::REG_PRECOND, 32'h81);
    for (int k = 0; k < 4; k++) begin
      lv <= {3'h0, 1'(k != 2)};
      linkOn <= k != 3;
      c = mk(ltu_pkg::CLASS_STATE, ltu_pkg::FUNC_AND, 1'b0, 1'(k == 1));
      trial(c, k < 2);
    end
    wr(ltu_pkg::REG_SRCSEL, 32'hC);
    wr(ltu_pkg::REG_SHLEVEL, 32'h8080);
    linkOn <= 1'b1;
    dOn <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      dDly <= k == 2 ? 88 : 4;
      wr(ltu_pkg::REG_HOLD, k == 0 ? 32'h3 : 32'h18);
      wr(ltu_pkg::REG_SETUP, k == 0 ? 32'h3 : 32'hFFEC);
      c = mk(ltu_pkg::CLASS_SETUP_HOLD, 2'h0, 1'b0, 1'b0);
      trial(c, k != 1);
    end
    dOn <= 1'b0;
    linkOn <= 1'b0;
    lv <= 4'h1;
    wr(ltu_pkg::REG_PRECOND, 32'h9);
    wr(ltu_pkg::REG_AUTOWAIT, 32'h12C);
    c = mk(ltu_pkg::CLASS_PATTERN, ltu_pkg::FUNC_NAND, 1'b0, 1'b0);
    wr(ltu_pkg::REG_CTRL, c | 32'h180);
    watch(1000, t, a);
    `CHK("auto acquisition", 2'b01, {t, a})
    wr(ltu_pkg::REG_CTRL, 32'h0);
    // raised first threshold turns the high channel one into a low
    wr(ltu_pkg::REG_THRESH, 32'h808080F8);
    trial(c, 1'b1);
    // true-span qualifier: a short and a long true pulse of the function
    wr(ltu_pkg::REG_THRESH, 32'h80808080);
    wr(ltu_pkg::REG_QUAL, 32'h64);
    lv <= 4'h2;
    for (int k = 0; k < 3; k++) begin
      c = mk(ltu_pkg::CLASS_PATTERN, ltu_pkg::FUNC_AND, 1'b0, 1'b0);
      c[ltu_pkg::CTRL_WHEN_LSB +: 2] = (k == 0) ?
        ltu_pkg::WHEN_TRUE_LESS : ltu_pkg::WHEN_TRUE_MORE;
      fork
        trial(c, k != 1);
        begin
          repeat (80) @(posedge core_clk);
          lv <= 4'h1;
          repeat (k == 2 ? 200 : 20) @(posedge core_clk);
          lv <= 4'h2;
        end
      join
    end
    summarize();
  end
endmodule : logic_trigger_unit_bench
bind ltu_core ltu_checker #(.HOLDOFF_MAX(HOLDOFF_MAX)) u_chk (
  .core_clk(core_clk), .nrst(nrst), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .chIn(chIn), .chLevel(chLevel),
  .trigPulse(trigPulse), .acqStart(acqStart));

// [verif/ltu_chan_model.sv]
/*
  four channel comparators in front of ltu_core: each compares its
  analog level with the level byte that the core drives.
  assumes analog levels given as bytes, channel i+1 in byte i.
*/
`timescale 1ns/100ps
module ltu_chan_model (
  // comparator levels from the core
  input wire logic [31:0] chLevel,
  // analog inputs
  input wire logic [31:0] anaLevel,
  // thresholded outputs
  output logic [3:0] chIn
);
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      chIn[i] = anaLevel[8*i +: 8] > chLevel[8*i +: 8];
    end
  end
endmodule : ltu_chan_model

// [verif/ltu_checker.sv]
/*
  port checker for ltu_core: pulse shape, holdoff spacing, run gating,
  read port idle value, class readback, levels and state clocking.
  assumes a bind from the bench top onto every ltu_core instance.
*/
`timescale 1ns/100ps
module ltu_checker #(
  parameter logic [31:0] HOLDOFF_MAX = 32'h3E8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdData,
  // channels and outputs
  input wire logic [3:0] chIn,
  input wire logic [31:0] chLevel,
  input wire logic trigPulse,
  input wire logic acqStart
);
  // ------------------------------------------------------------------
  // shadows of written fields
  // ------------------------------------------------------------------
  logic [8:0] ctl;
  logic [31:0] thr;
  logic [7:0] gap;
  logic [5:0] hist;
  logic [1:0] rdCls;
  wire wrCtl = regWr && regAddr == ltu_pkg::REG_CTRL;
  wire wrThr = regWr && regAddr == ltu_pkg::REG_THRESH;
  wire notSh = ctl[1:0] != ltu_pkg::CLASS_SETUP_HOLD;
  // window allows for the two-flop input latency and async jitter
  wire [3:0] rise = hist[4:1] & ~hist[5:2];
  wire [3:0] fall = ~hist[4:1] & hist[5:2];
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ctl <= ltu_pkg::CTRL_RST;
      thr <= {4{ltu_pkg::THRESH_RST}};
      gap <= 8'hFF;
    end else begin
      if (wrCtl) ctl <= regWrData[8:0];
      if (wrThr) thr <= regWrData;
      gap <= acqStart ? 8'h00 : (gap == 8'hFF ? gap : gap + 8'h01);
    end
    hist <= {hist[4:0], chIn[3]};
    rdCls <= ctl[1:0];
  end
  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  trig_acq_a: assert property (trigPulse |-> acqStart)
    else $error("trigger without acquisition start");
  pulse_single_a: assert property (trigPulse |=> !trigPulse)
    else $error("trigger pulse longer than one cycle");
  holdoff_gap_a: assert property (trigPulse |-> gap >= 8'h3E)
    else $error("trigger inside holdoff");
  run_gate_a: assert property (!ctl[8] && !$past(ctl[8]) |-> !acqStart)
    else $error("acquisition while stopped");
  rd_idle_a: assert property (!$past(regRd) |-> regRdData == 32'h0)
    else $error("read data outside read answer cycle");
  class_read_a: assert property (
    $past(regRd && regAddr == ltu_pkg::REG_STATUS) |-> regRdData[1:0] == rdCls)
    else $error("status class differs from control");
  level_map_a: assert property (
    notSh && $past(notSh) && $stable(thr) |-> chLevel == thr)
    else $error("channel level differs from threshold");
  state_edge_a: assert property (
    trigPulse && ctl[1:0] == ltu_pkg::CLASS_STATE |->
      (ctl[6] ? fall : rise) != 4'h0)
    else $error("state trigger without clock edge");
  cover property (trigPulse && ctl[1:0] == ltu_pkg::CLASS_PATTERN);
  cover property (trigPulse && ctl[1:0] == ltu_pkg::CLASS_STATE);
  cover property (trigPulse && !notSh);
  cover property (acqStart && !trigPulse);
endmodule : ltu_checker

// [verilog/ltu_core.sv]
/*
  logic trigger unit: pattern, state and setup/hold trigger classes
  over four thresholded channels, with holdoff and auto mode.
  assumes the channel bits come from comparators outside the core
  clock domain, and a single-cycle register port master.
*/
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
module ltu_core #(
  parameter logic [31:0] HOLDOFF_MAX = 32'(ltu_pkg::HOLDOFF_MAX_CYC)
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  // thresholded channels
  input wire logic [3:0] chIn,
  // comparator levels, channel i+1 in bits 8i+7:8i
  output logic [31:0] chLevel,
  // trigger outputs
  output logic trigPulse,
  output logic acqStart
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [8:0] ctrl;
  logic [7:0] precond;
  logic [3:0] srcSel;
  logic [15:0] setupT;
  logic [15:0] holdT;
  logic [23:0] qualT;
  logic [31:0] holdoffT;
  logic [31:0] autoWait;
  logic [31:0] thresh;
  logic [15:0] shLevel;
  logic [15:0] trigCount;

  wire logic [1:0] cls = ctrl[ltu_pkg::CTRL_CLASS_LSB +: 2];
  wire logic [1:0] func = ctrl[ltu_pkg::CTRL_FUNC_LSB +: 2];
  wire logic [1:0] whenSel = ctrl[ltu_pkg::CTRL_WHEN_LSB +: 2];
  wire logic edgeFall = ctrl[ltu_pkg::CTRL_EDGE_BIT];
  wire logic autoMode = ctrl[ltu_pkg::CTRL_AUTO_BIT];
  wire logic run = ctrl[ltu_pkg::CTRL_RUN_BIT];
  wire logic [1:0] dataSel = srcSel[ltu_pkg::SRC_DATA_LSB +: 2];
  wire logic [1:0] clkSel = srcSel[ltu_pkg::SRC_CLK_LSB +: 2];

  wire logic wrSetup = regWr && regAddr == ltu_pkg::REG_SETUP;
  wire logic wrHold = regWr && regAddr == ltu_pkg::REG_HOLD;
  wire logic signed [17:0] sumMin = 18'(ltu_pkg::SH_SUM_MIN_CYC);
  wire logic signed [17:0] newS = 18'(signed'(regWrData[15:0]));
  wire logic signed [17:0] newH = 18'(signed'(regWrData[15:0]));
  wire logic signed [17:0] curS = 18'(signed'(setupT));
  wire logic signed [17:0] curH = 18'(signed'(holdT));
  // a write that breaks the minimum sum drags the other time along
  wire logic fixHold = wrSetup && (newS + curH < sumMin);
  wire logic fixSetup = wrHold && (curS + newH < sumMin);
  wire logic [17:0] adjHold = 18'(sumMin - newS);
  wire logic [17:0] adjSetup = 18'(sumMin - newH);

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ctrl <= ltu_pkg::CTRL_RST;
      precond <= ltu_pkg::PRECOND_RST;
      srcSel <= ltu_pkg::SRCSEL_RST;
      setupT <= ltu_pkg::SETUP_RST;
      holdT <= ltu_pkg::HOLD_RST;
      qualT <= ltu_pkg::QUAL_RST;
      holdoffT <= ltu_pkg::HOLDOFF_RST;
      autoWait <= ltu_pkg::AUTOWAIT_RST;
      thresh <= {4{ltu_pkg::THRESH_RST}};
      shLevel <= {2{ltu_pkg::THRESH_RST}};
    end else if (regWr) begin
      case (regAddr)
        ltu_pkg::REG_CTRL: ctrl <= regWrData[8:0];
        ltu_pkg::REG_PRECOND: precond <= regWrData[7:0];
        ltu_pkg::REG_SRCSEL: srcSel <= regWrData[3:0];
        ltu_pkg::REG_SETUP: begin
          setupT <= regWrData[15:0];
          if (fixHold) holdT <= adjHold[15:0];
        end
        ltu_pkg::REG_HOLD: begin
          holdT <= regWrData[15:0];
          if (fixSetup) setupT <= adjSetup[15:0];
        end
        ltu_pkg::REG_QUAL: qualT <= regWrData[23:0];
        ltu_pkg::REG_HOLDOFF: holdoffT <= regWrData;
        ltu_pkg::REG_AUTOWAIT: autoWait <= regWrData;
        ltu_pkg::REG_THRESH: thresh <= regWrData;
        ltu_pkg::REG_SHLEVEL: shLevel <= regWrData[15:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // channel synchronisers and edge history
  // ----------------------------------------------------------------
  logic [3:0] chMeta;
  logic [3:0] chSync;
  logic [3:0] chPrev;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      chMeta <= 4'h0;
      chSync <= 4'h0;
      chPrev <= 4'h0;
    end else begin
      chMeta <= chIn;
      chSync <= chMeta;
      chPrev <= chSync;
    end
  end

  // ----------------------------------------------------------------
  // precondition matching and logic function
  // ----------------------------------------------------------------
  wire logic isPattern = cls == ltu_pkg::CLASS_PATTERN;
  wire logic isState = cls == ltu_pkg::CLASS_STATE;
  wire logic isSh = cls == ltu_pkg::CLASS_SETUP_HOLD;
  logic [3:0] met;
  logic [3:0] care;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ch
      wire logic [1:0] pc = precond[2*gi +: 2];
      assign met[gi] = (pc == ltu_pkg::PRE_HIGH && chSync[gi]) ||
        (pc == ltu_pkg::PRE_LOW && !chSync[gi]);
      // the fourth channel is the clock in state class
      assign care[gi] = (pc == ltu_pkg::PRE_HIGH ||
        pc == ltu_pkg::PRE_LOW) && !(isState && gi == 3);
      wire logic useClk = isSh && clkSel == 2'(gi);
      wire logic useData = isSh && dataSel == 2'(gi);
      wire logic [7:0] lvl = useClk ? shLevel[15:8] :
        useData ? shLevel[7:0] : thresh[8*gi +: 8];
      always_ff @(posedge core_clk) begin
        if (!nrst) chLevel[8*gi +: 8] <= ltu_pkg::THRESH_RST;
        else chLevel[8*gi +: 8] <= lvl;
      end
    end
  endgenerate

  wire logic allMet = &(met | ~care);
  wire logic anyMet = |(met & care);
  wire logic goesFalse = whenSel == ltu_pkg::WHEN_FALL_FALSE;
  wire logic [1:0] funcEff = goesFalse ? (func ^ 2'h1) : func;
  wire logic fVal =
    (funcEff == ltu_pkg::FUNC_AND) ? allMet :
    (funcEff == ltu_pkg::FUNC_NAND) ? !allMet :
    (funcEff == ltu_pkg::FUNC_OR) ? anyMet : !anyMet;

  // ----------------------------------------------------------------
  // holdoff and auto timer
  // ----------------------------------------------------------------
  logic [31:0] hoCnt;
  logic [31:0] autoCnt;
  wire logic hoDone = hoCnt == 32'h0;
  wire logic [31:0] hoMin = 32'(ltu_pkg::HOLDOFF_MIN_CYC);
  wire logic [31:0] hoEff = (holdoffT < hoMin) ? hoMin :
    (holdoffT > HOLDOFF_MAX) ? HOLDOFF_MAX : holdoffT;
  wire logic armed = run && hoDone;

  // ----------------------------------------------------------------
  // time-qualified pattern
  // ----------------------------------------------------------------
  logic fPrev;
  logic [23:0] trueCnt;
  wire logic qualMode = whenSel == ltu_pkg::WHEN_TRUE_LESS ||
    whenSel == ltu_pkg::WHEN_TRUE_MORE;
  wire logic fFell = fPrev && !fVal;
  wire logic qualOk = (whenSel == ltu_pkg::WHEN_TRUE_LESS) ?
    (trueCnt < qualT) : (trueCnt > qualT);
  wire logic patHit = qualMode ? (fFell && qualOk) : fVal;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      fPrev <= 1'b0;
      trueCnt <= 24'h0;
    end else begin
      fPrev <= fVal;
      // counts true span from assertion; saturates on long pulses
      if (!fVal) trueCnt <= 24'h0;
      else if (trueCnt != 24'hFFFFFF) trueCnt <= trueCnt + 24'h1;
    end
  end

  // ----------------------------------------------------------------
  // state class
  // ----------------------------------------------------------------
  wire logic ch4Rise = chSync[3] && !chPrev[3];
  wire logic ch4Fall = !chSync[3] && chPrev[3];
  wire logic ch4Edge = edgeFall ? ch4Fall : ch4Rise;
  wire logic stateHit = ch4Edge && fVal;

  // ----------------------------------------------------------------
  // setup/hold class
  // ----------------------------------------------------------------
  logic [15:0] dtAge;
  logic [15:0] ceAge;
  logic clkSeen;
  wire logic dNow = chSync[dataSel];
  wire logic dOld = chPrev[dataSel];
  wire logic cNow = chSync[clkSel];
  wire logic cOld = chPrev[clkSel];
  wire logic dataEdge = dNow ^ dOld;
  wire logic clkEdge = edgeFall ? (cOld && !cNow) : (!cOld && cNow);
  wire logic [15:0] ageNow = dataEdge ? 16'h0 : dtAge;
  wire logic signed [17:0] sAge = signed'({2'b00, ageNow});
  wire logic signed [17:0] sCe = signed'({2'b00, ceAge});
  // zone runs from setup before the edge to hold after it; a negative
  // value pushes one end past the edge so the zone sits to one side
  wire logic preHit = clkEdge && sAge <= curS && sAge >= -curH;
  wire logic postHit = dataEdge && !clkEdge && clkSeen &&
    sCe >= 18'sd1 && sCe <= curH && sCe >= -curS;
  wire logic shHit = preHit || postHit;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      dtAge <= ltu_pkg::AGE_MAX;
      ceAge <= ltu_pkg::AGE_MAX;
    end else begin
      if (dataEdge) dtAge <= 16'h1;
      else if (dtAge != ltu_pkg::AGE_MAX) dtAge <= dtAge + 16'h1;
      if (clkEdge) ceAge <= 16'h1;
      else if (ceAge != ltu_pkg::AGE_MAX) ceAge <= ceAge + 16'h1;
    end
  end

  // ----------------------------------------------------------------
  // trigger selection
  // ----------------------------------------------------------------
  wire logic classHit = isPattern ? patHit :
    isState ? stateHit : isSh ? shHit : 1'b0;
  wire logic trig = armed && classHit;
  wire logic autoForce = armed && autoMode && !trig &&
    autoCnt >= autoWait;
  wire logic acq = trig || autoForce;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      hoCnt <= 32'h0;
      autoCnt <= 32'h0;
      clkSeen <= 1'b0;
      trigPulse <= 1'b0;
      acqStart <= 1'b0;
      trigCount <= 16'h0;
    end else begin
      trigPulse <= trig;
      // the pulse marks the clock edge itself for a before-edge hit
      acqStart <= acq;
      if (acq) hoCnt <= hoEff;
      else if (!hoDone) hoCnt <= hoCnt - 32'h1;
      if (acq || !run || !autoMode) autoCnt <= 32'h0;
      else if (autoCnt != 32'hFFFFFFFF) autoCnt <= autoCnt + 32'h1;
      // only edges seen with holdoff over may anchor a hold violation
      if (acq || !armed) clkSeen <= 1'b0;
      else if (clkEdge) clkSeen <= 1'b1;
      if (trig) trigCount <= trigCount + 16'h1;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  wire logic [31:0] statusWord =
    {trigCount, 12'h0, fVal, !hoDone, cls};
  wire logic [31:0] rdMux =
    (regAddr == ltu_pkg::REG_CTRL) ? {23'h0, ctrl} :
    (regAddr == ltu_pkg::REG_PRECOND) ? {24'h0, precond} :
    (regAddr == ltu_pkg::REG_SRCSEL) ? {28'h0, srcSel} :
    (regAddr == ltu_pkg::REG_SETUP) ? {16'h0, setupT} :
    (regAddr == ltu_pkg::REG_HOLD) ? {16'h0, holdT} :
    (regAddr == ltu_pkg::REG_QUAL) ? {8'h0, qualT} :
    (regAddr == ltu_pkg::REG_HOLDOFF) ? holdoffT :
    (regAddr == ltu_pkg::REG_AUTOWAIT) ? autoWait :
    (regAddr == ltu_pkg::REG_THRESH) ? thresh :
    (regAddr == ltu_pkg::REG_SHLEVEL) ? {16'h0, shLevel} :
    (regAddr == ltu_pkg::REG_STATUS) ? statusWord : 32'h0;
  always_ff @(posedge core_clk) begin
    if (!nrst) regRdData <= 32'h0;
    else regRdData <= regRd ? rdMux : 32'h0;
  end
endmodule : ltu_core

// [verilog/ltu_pkg.sv]
/*
  constants for the logic trigger unit: register offsets, field
  positions, encodings, reset values and timing counts.
  assumes a 250 MHz core clock and a byte-addressed register port.
*/
package ltu_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int HOLDOFF_MIN_NS = 250;
  localparam longint HOLDOFF_MAX_S = 12;
  localparam int SH_SUM_MIN_NS = 2;
  localparam int HOLDOFF_MIN_CYC =
    (HOLDOFF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam longint HOLDOFF_MAX_CYC =
    HOLDOFF_MAX_S * 64'd1000000000 / CLK_PERIOD_NS;
  localparam int SH_SUM_MIN_RAW =
    (SH_SUM_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SH_SUM_MIN_CYC = (SH_SUM_MIN_RAW < 1) ? 1 : SH_SUM_MIN_RAW;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PRECOND = 8'h04;
  localparam logic [7:0] REG_SRCSEL = 8'h08;
  localparam logic [7:0] REG_SETUP = 8'h0C;
  localparam logic [7:0] REG_HOLD = 8'h10;
  localparam logic [7:0] REG_QUAL = 8'h14;
  localparam logic [7:0] REG_HOLDOFF = 8'h18;
  localparam logic [7:0] REG_AUTOWAIT = 8'h1C;
  localparam logic [7:0] REG_THRESH = 8'h20;
  localparam logic [7:0] REG_SHLEVEL = 8'h24;
  localparam logic [7:0] REG_STATUS = 8'h28;
  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int CTRL_CLASS_LSB = 0;
  localparam int CTRL_FUNC_LSB = 2;
  localparam int CTRL_WHEN_LSB = 4;
  localparam int CTRL_EDGE_BIT = 6;
  localparam int CTRL_AUTO_BIT = 7;
  localparam int CTRL_RUN_BIT = 8;
  localparam int SRC_DATA_LSB = 0;
  localparam int SRC_CLK_LSB = 2;
  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] CLASS_PATTERN = 2'h0;
  localparam logic [1:0] CLASS_STATE = 2'h1;
  localparam logic [1:0] CLASS_SETUP_HOLD = 2'h2;
  localparam logic [1:0] FUNC_AND = 2'h0;
  localparam logic [1:0] FUNC_NAND = 2'h1;
  localparam logic [1:0] FUNC_OR = 2'h2;
  localparam logic [1:0] FUNC_NOR = 2'h3;
  localparam logic [1:0] WHEN_RISE_TRUE = 2'h0;
  localparam logic [1:0] WHEN_FALL_FALSE = 2'h1;
  localparam logic [1:0] WHEN_TRUE_LESS = 2'h2;
  localparam logic [1:0] WHEN_TRUE_MORE = 2'h3;
  localparam logic [1:0] PRE_DONT_CARE = 2'h0;
  localparam logic [1:0] PRE_HIGH = 2'h1;
  localparam logic [1:0] PRE_LOW = 2'h2;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [8:0] CTRL_RST = 9'h000;
  localparam logic [7:0] PRECOND_RST = 8'h00;
  localparam logic [3:0] SRCSEL_RST = 4'h4;
  localparam logic [15:0] SETUP_RST = 16'h0001;
  localparam logic [15:0] HOLD_RST = 16'h0001;
  localparam logic [23:0] QUAL_RST = 24'h000100;
  localparam logic [31:0] HOLDOFF_RST = 32'h0000003F;
  localparam logic [31:0] AUTOWAIT_RST = 32'h00100000;
  localparam logic [7:0] THRESH_RST = 8'h80;
  localparam logic [15:0] AGE_MAX = 16'hFFFF;
endpackage : ltu_pkg
